// >>> hdl/cat_cfg.svh
// constants for the counter array timebase: register offsets, field
// positions, reset values and divider counts.
// assumes a 100 MHz system clock and an APB bus with 32-bit data.
// ----------------------------------------------------------------
// Contract
// - counter is 16 bits, seen by software as low and high byte registers
// - reading the low byte latches the high byte; high read returns that latch
// - reading either count byte never disturbs counting
// - timebase 000 sysclk/12, 001 sysclk/4, 100 sysclk
// - timebase 010 counts timer 0 overflows, 011 falling edges of count input
// - timebase 101 external osc/8, 110 low-frequency osc/8, 111 reserved
// - every non-sysclk source is synchronised before counting; timer 0 overflow enters the timebase unsynchronised
// - wrap from ffff to 0000 sets the counter overflow flag
// - counter overflow requests interrupt only when its enable bit is set
// - idle-stop bit low lets the array run during cpu idle
// - intermediate overflow flag set by carry out of bit 8, 9, 10 or 11; the code sets it on carry out of bit 7, 8, 9 or 10
// - each of three channels has its own mode-driven event flag
// - flags set on their trigger regardless of interrupt enables
// - each flag has its own enable into the interrupt request
// - request reaches cpu only with global and array enables both set
// - five flags merge into one array interrupt request
// - three 16-bit capture/compare channels share the counter, each with a pin
// - channel 2 acts as watchdog, enabled after every reset
// - watchdog mode restricts software access to some registers
// ----------------------------------------------------------------
`ifndef CAT_CFG_SVH
`define CAT_CFG_SVH

// register byte offsets
`define CAT_OFS_CNT_LOW 12'h000
`define CAT_OFS_CNT_HIGH 12'h004
`define CAT_OFS_MODE 12'h008
`define CAT_OFS_FLAGS 12'h00c
`define CAT_OFS_IRQEN 12'h010
`define CAT_OFS_CH_MODE 12'h020
`define CAT_OFS_CH_VAL 12'h030
`define CAT_OFS_CH_SPAN 12'h00c

// mode register fields
`define CAT_MODE_OVF_IE 0
`define CAT_MODE_TB_LSB 1
`define CAT_MODE_WDT 6
`define CAT_MODE_IDLE 7
`define CAT_MODE_WDT_RST 1'b1

// flag and enable register fields
`define CAT_FLAG_INTERMEDIATE_OVERFLOW_FLAG 3
`define CAT_FLAG_CF 4
`define CAT_IRQEN_INTERMEDIATE_OVERFLOW_FLAG 3
`define CAT_IRQEN_SEL_LSB 4

// channel mode fields
`define CAT_CH_CAP_POS 0
`define CAT_CH_CAP_NEG 1
`define CAT_CH_MATCH 2
`define CAT_CH_PIN 3
`define CAT_WDT_CH 2

// timebase codes
`define CAT_TB_DIV12 3'h0
`define CAT_TB_DIV4 3'h1
`define CAT_TB_T0 3'h2
`define CAT_TB_ECI 3'h3
`define CAT_TB_SYS 3'h4
`define CAT_TB_EXT 3'h5
`define CAT_TB_LF 3'h6

// divider counts and masks
`define CAT_DIV12_LAST 4'hb
`define CAT_DIV4_LAST 2'h3
`define CAT_OSC_DIV_LAST 3'h7
`define CAT_CNT_MAX 16'hffff
`define CAT_INTERMEDIATE_OVERFLOW_FLAG_MASK 16'h07ff

// synchroniser bit positions
`define CAT_SYN_ECI 0
`define CAT_SYN_EXT 1
`define CAT_SYN_LF 2
`define CAT_SYN_CH 3

`endif

// >>> hdl/cat_pkg.sv
// types shared by the counter array timebase block.
// assumes cat_cfg.svh is compiled alongside for the constants.
package cat_pkg;

   // apb request from master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } cat_apb_req_t;

   // apb answer to master
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } cat_apb_rsp_t;

   // whole block state
   typedef struct packed {
      logic [15:0] count;
      logic [7:0] snap;
      logic [31:0] prdata;
      logic perr;
      logic [3:0] div;
      logic [2:0] extDiv;
      logic [2:0] lfDiv;
      logic [5:0] s1;
      logic [5:0] s2;
      logic [5:0] s3;
      logic [5:0] filt;
      logic ovfIe;
      logic [2:0] tbSel;
      logic wdtEn;
      logic idleStop;
      logic [1:0] covfSel;
      logic covfIe;
      logic [2:0] chIe;
      logic cf;
      logic intermediate_overflow_flag;
      logic [2:0] ccf;
      logic [2:0][3:0] chMode;
      logic [2:0][15:0] chVal;
      logic [2:0] chOut;
      logic wdtRst;
   } cat_state_t;

endpackage

// >>> hdl/cat_timebase.sv
// counter array core: 16-bit counter, timebase, snapshot read,
// three capture/compare channels, watchdog channel, interrupt tree.
// assumes an APB master on clk and raw pins from outside the domain.
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "cat_cfg.svh"

module cat_timebase (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register bus
   input wire cat_pkg::cat_apb_req_t apbReq,
   output cat_pkg::cat_apb_rsp_t apbRsp,
   // pins and sources from outside the clock domain
   input wire logic externalCountInput,
   input wire logic extOscClk,
   input wire logic lfOscClk,
   input wire logic [2:0] channelIoIn,
   // same-domain inputs
   input wire logic timer0Overflow,
   input wire logic cpuIdle,
   input wire logic globalIrqEnable,
   input wire logic arrayIrqEnable,
   // channel pins
   output logic [2:0] channelIoOut,
   output logic [2:0] channelIoOe_n,
   // requests
   output logic irqRequest,
   output logic watchdogReset
);

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------

   // {hit, index} for a register bank of three words at base
   function automatic logic [2:0] chHit(input logic [11:0] a, input logic [11:0] base);
      logic [11:0] d;
      d = a - base;
      chHit = {(a >= base) && (d < `CAT_OFS_CH_SPAN) && (a[1:0] == 2'h0), d[3:2]};
   endfunction

   cat_pkg::cat_state_t r;
   cat_pkg::cat_state_t n;

   logic [5:0] rise;
   logic [5:0] fall;
   logic tick;
   logic halt;
   logic adv;
   logic [15:0] covfMask;
   logic [7:0] modeByte;
   logic rdSetup;
   logic wrAccess;
   logic [2:0] hitMode;
   logic [2:0] hitVal;

   // ----------------------------------------------------------------
   // synchronised edges
   // ----------------------------------------------------------------

   // an edge counts only once the second and third stages agree
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : gEdge
         assign rise[g] = (r.s2[g] == r.s3[g]) && r.s3[g] && !r.filt[g];
         assign fall[g] = (r.s2[g] == r.s3[g]) && !r.s3[g] && r.filt[g];
      end
   endgenerate

   // ----------------------------------------------------------------
   // timebase select
   // ----------------------------------------------------------------

   // one tick per count step; 111 yields no tick at all
   always_comb begin
      case (r.tbSel)
         `CAT_TB_DIV12: tick = (r.div == `CAT_DIV12_LAST);
         `CAT_TB_DIV4: tick = (r.div[1:0] == `CAT_DIV4_LAST);
         `CAT_TB_T0: tick = timer0Overflow;
         `CAT_TB_ECI: tick = fall[`CAT_SYN_ECI];
         `CAT_TB_SYS: tick = 1'b1;
         `CAT_TB_EXT: tick = fall[`CAT_SYN_EXT] && (r.extDiv == `CAT_OSC_DIV_LAST);
         `CAT_TB_LF: tick = fall[`CAT_SYN_LF] && (r.lfDiv == `CAT_OSC_DIV_LAST);
         default: tick = 1'b0;
      endcase
   end

   // idle stop freezes the count, otherwise the array ignores idle
   assign halt = cpuIdle && r.idleStop;
   assign adv = tick && !halt;
   assign covfMask = `CAT_INTERMEDIATE_OVERFLOW_FLAG_MASK >> (2'h3 - r.covfSel);

   // bus phases
   assign rdSetup = apbReq.psel && !apbReq.penable && !apbReq.pwrite;
   assign wrAccess = apbReq.psel && apbReq.penable && apbReq.pwrite;
   assign hitMode = chHit(apbReq.paddr, `CAT_OFS_CH_MODE);
   assign hitVal = chHit(apbReq.paddr, `CAT_OFS_CH_VAL);
   assign modeByte = {r.idleStop, r.wdtEn, 2'h0, r.tbSel, r.ovfIe};

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------

   always_comb begin
      n = r;
      n.wdtRst = 1'b0;

      // three-stage synchronisers for all foreign inputs
      n.s1 = {channelIoIn, lfOscClk, extOscClk, externalCountInput};
      n.s2 = r.s1;
      n.s3 = r.s2;
      for (int k = 0; k < 6; k++) begin
         if (r.s2[k] == r.s3[k]) begin
            n.filt[k] = r.s3[k];
         end
      end

      // prescaler runs always so the divided rates stay regular
      if (r.div == `CAT_DIV12_LAST) begin
         n.div = 4'h0;
      end else begin
         n.div = r.div + 4'h1;
      end
      if (fall[`CAT_SYN_EXT]) begin
         n.extDiv = r.extDiv + 3'h1;
      end
      if (fall[`CAT_SYN_LF]) begin
         n.lfDiv = r.lfDiv + 3'h1;
      end

      // counter step; reads never enter this path
      if (adv) begin
         n.count = r.count + 16'h0001;
      end

      // channels: capture on pin edges, match on count steps
      for (int k = 0; k < 3; k++) begin
         if ((r.chMode[k][`CAT_CH_CAP_POS] && rise[`CAT_SYN_CH + k])
               || (r.chMode[k][`CAT_CH_CAP_NEG] && fall[`CAT_SYN_CH + k])) begin
            n.chVal[k] = r.count;
         end
      end

      // ---------------- register bus ----------------
      // read data is taken in setup so the access phase answers at once
      if (rdSetup) begin
         n.prdata = 32'h0;
         n.perr = 1'b0;
         if (apbReq.paddr == `CAT_OFS_CNT_LOW) begin
            n.prdata[7:0] = r.count[7:0];
            n.snap = r.count[15:8];
         end else if (apbReq.paddr == `CAT_OFS_CNT_HIGH) begin
            n.prdata[7:0] = r.snap;
         end else if (apbReq.paddr == `CAT_OFS_MODE) begin
            n.prdata[7:0] = modeByte;
         end else if (apbReq.paddr == `CAT_OFS_FLAGS) begin
            n.prdata[4:0] = {r.cf, r.intermediate_overflow_flag, r.ccf};
         end else if (apbReq.paddr == `CAT_OFS_IRQEN) begin
            n.prdata[5:0] = {r.covfSel, r.covfIe, r.chIe};
         end else if (hitMode[2]) begin
            n.prdata[3:0] = r.chMode[hitMode[1:0]];
         end else if (hitVal[2]) begin
            n.prdata[15:0] = r.chVal[hitVal[1:0]];
         end else begin
            n.perr = 1'b1;
         end
      end else if (apbReq.psel && !apbReq.penable) begin
         n.prdata = 32'h0;
         n.perr = 1'b0;
         if (apbReq.paddr != `CAT_OFS_CNT_LOW && apbReq.paddr != `CAT_OFS_CNT_HIGH
               && apbReq.paddr != `CAT_OFS_MODE && apbReq.paddr != `CAT_OFS_FLAGS
               && apbReq.paddr != `CAT_OFS_IRQEN && !hitMode[2] && !hitVal[2]) begin
            n.perr = 1'b1;
         end
      end

      // writes land at the access edge; a written count byte beats a step, the other byte still takes the step
      if (wrAccess) begin
         if (apbReq.paddr == `CAT_OFS_CNT_LOW) begin
            n.count[7:0] = apbReq.pwdata[7:0];
         end else if (apbReq.paddr == `CAT_OFS_CNT_HIGH) begin
            n.count[15:8] = apbReq.pwdata[7:0];
         end else if (apbReq.paddr == `CAT_OFS_MODE) begin
            // while the watchdog runs only its own enable may change
            n.wdtEn = apbReq.pwdata[`CAT_MODE_WDT];
            if (!r.wdtEn) begin
               n.ovfIe = apbReq.pwdata[`CAT_MODE_OVF_IE];
               n.tbSel = apbReq.pwdata[`CAT_MODE_TB_LSB +: 3];
               n.idleStop = apbReq.pwdata[`CAT_MODE_IDLE];
            end
         end else if (apbReq.paddr == `CAT_OFS_FLAGS) begin
            // write one to clear; hardware sets below win
            n.ccf = r.ccf & ~apbReq.pwdata[2:0];
            n.intermediate_overflow_flag = r.intermediate_overflow_flag && !apbReq.pwdata[`CAT_FLAG_INTERMEDIATE_OVERFLOW_FLAG];
            n.cf = r.cf && !apbReq.pwdata[`CAT_FLAG_CF];
         end else if (apbReq.paddr == `CAT_OFS_IRQEN) begin
            n.chIe = apbReq.pwdata[2:0];
            n.covfIe = apbReq.pwdata[`CAT_IRQEN_INTERMEDIATE_OVERFLOW_FLAG];
            n.covfSel = apbReq.pwdata[`CAT_IRQEN_SEL_LSB +: 2];
         end else if (hitMode[2]) begin
            if (!(r.wdtEn && hitMode[1:0] == 2'(`CAT_WDT_CH))) begin
               n.chMode[hitMode[1:0]] = apbReq.pwdata[3:0];
            end
         end else if (hitVal[2]) begin
            n.chVal[hitVal[1:0]] = apbReq.pwdata[15:0];
         end
      end

      // ---------------- flag sets, after clears ----------------
      if (adv && r.count == `CAT_CNT_MAX) begin
         n.cf = 1'b1;
      end
      if (adv && (r.count & covfMask) == covfMask) begin
         n.intermediate_overflow_flag = 1'b1;
      end
      for (int k = 0; k < 3; k++) begin
         if ((r.chMode[k][`CAT_CH_CAP_POS] && rise[`CAT_SYN_CH + k])
               || (r.chMode[k][`CAT_CH_CAP_NEG] && fall[`CAT_SYN_CH + k])) begin
            n.ccf[k] = 1'b1;
         end
         if (adv && r.chMode[k][`CAT_CH_MATCH] && r.count == r.chVal[k]) begin
            if (k == `CAT_WDT_CH && r.wdtEn) begin
               n.wdtRst = 1'b1;
            end else begin
               n.ccf[k] = 1'b1;
               n.chOut[k] = !r.chOut[k];
            end
         end
      end
      // the watchdog also fires with a cleared match bit so only clearing its enable disarms it
      if (r.wdtEn && adv && !r.chMode[`CAT_WDT_CH][`CAT_CH_MATCH]
            && r.count == r.chVal[`CAT_WDT_CH]) begin
         n.wdtRst = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------

   always_ff @(posedge clk) begin
      if (reset) begin
         r <= '0;
         r.wdtEn <= `CAT_MODE_WDT_RST;
      end else begin
         r <= n;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------

   // zero-wait slave: data was prepared in the setup cycle
   assign apbRsp.prdata = r.prdata;
   assign apbRsp.pready = 1'b1;
   assign apbRsp.pslverr = r.perr;

   // five flags through their own enables, then the cpu-side gates
   assign irqRequest = globalIrqEnable && arrayIrqEnable
      && ((r.cf && r.ovfIe) || (r.intermediate_overflow_flag && r.covfIe) || |(r.ccf & r.chIe));

   assign watchdogReset = r.wdtRst;

   // channel pins are driven only when the pin bit is set
   generate
      for (g = 0; g < 3; g++) begin : gPin
         assign channelIoOut[g] = r.chOut[g];
         assign channelIoOe_n[g] = !r.chMode[g][`CAT_CH_PIN];
      end
   endgenerate

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_snap_latch: assert property (rdSetup && apbReq.paddr == `CAT_OFS_CNT_LOW
      |=> r.snap == $past(r.count[15:8]) && r.prdata[7:0] == $past(r.count[7:0]))
      else $error("snapshot not latched on low read");

   a_high_read: assert property (rdSetup && apbReq.paddr == `CAT_OFS_CNT_HIGH
      |=> r.prdata[7:0] == $past(r.snap))
      else $error("high read did not return snapshot");

   a_count_step: assert property (adv && !wrAccess |=> r.count == $past(r.count) + 16'h0001)
      else $error("counter did not step");

   a_cf_wrap: assert property (adv && r.count == `CAT_CNT_MAX |=> r.cf && r.count == 16'h0)
      else $error("overflow flag not set on wrap");

   a_cf_sticky: assert property (r.cf && !(wrAccess && apbReq.paddr == `CAT_OFS_FLAGS)
      |=> r.cf)
      else $error("overflow flag cleared by hardware");

   a_idle_hold: assert property (halt && !wrAccess ##1 halt && !wrAccess
      |-> $stable(r.count))
      else $error("counter moved in idle stop");

   a_div12_gap: assert property (tick && r.tbSel == `CAT_TB_DIV12
      |=> !(tick && r.tbSel == `CAT_TB_DIV12) [*8])
      else $error("divide by twelve tick too close");

   a_irq_cf: assert property (r.cf && r.ovfIe && globalIrqEnable && arrayIrqEnable
      |-> irqRequest)
      else $error("enabled overflow gave no request");

   a_irq_gated: assert property (!arrayIrqEnable |-> !irqRequest)
      else $error("request without array enable");

   a_wdt_lock: assert property (r.wdtEn && wrAccess && apbReq.paddr == `CAT_OFS_MODE
      |=> r.tbSel == $past(r.tbSel) && r.idleStop == $past(r.idleStop))
      else $error("mode changed under watchdog");

   a_wdt_reset: assert property ($fell(reset) |-> r.wdtEn)
      else $error("watchdog not enabled after reset");

endmodule

`default_nettype wire

// >>> verification/cat_partner.sv
// far-side model: timer 0 overflow pulses, count pin and two oscillators.
// assumes clk is the system clock; outputs move only just after its edge.
`timescale 1ns/1ps
`default_nettype none
module cat_partner (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // sources toward the array
   output logic t0Ovf,
   output logic external_count_input,
   output logic extOsc,
   output logic lfOsc
);
   // ------------------------------------------------
   // shared phase counter
   // ------------------------------------------------
   logic [7:0] tick;

   // one 30-cycle frame keeps every source periodic, so counts are exact
   always_ff @(posedge clk) begin
      if (reset) begin
         tick <= 8'h00;
      end else begin
         tick <= (tick == 8'h1d) ? 8'h00 : tick + 8'h01;
      end
   end

   // timer 0 every 6 cycles; count pin period 10, slower than sysclk/4
   assign t0Ovf = (tick % 8'h06) == 8'h00;
   assign external_count_input = (tick % 8'h0a) < 8'h05;
   // oscillators free-run with periods 6 and 10, unaligned to each other
   assign extOsc = (tick % 8'h06) < 8'h03;
   assign lfOsc = (tick % 8'h0a) >= 8'h05;
endmodule
`default_nettype wire

// >>> verification/counter_array_timebase_irq_tb.sv
// self-checking bench for the counter array timebase block.
// assumes cat_pkg, cat_cfg.svh and cat_partner are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "cat_cfg.svh"
module counter_array_timebase_irq_tb;
   // ------------------------------------------------
   // stimulus and wiring
   // ------------------------------------------------
   logic clk = 1'b0;
   logic reset = 1'b1;
   cat_pkg::cat_apb_req_t apbReq = '0;
   cat_pkg::cat_apb_rsp_t apbRsp;
   logic t0Ovf, external_count_input, extOsc, lfOsc, irq, wdtRst;
   logic cpuIdle = 1'b0;
   logic gie = 1'b1;
   logic aie = 1'b1;
   logic [2:0] chIn = 3'h0;
   logic [2:0] chOut, chOe_n;
   logic [31:0] rdq;
   logic rerr;
   logic [7:0] lo, hi, dl;
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;
   int n;

   always #5 clk = ~clk;

   cat_timebase u_cat_timebase (
      .clk(clk), .reset(reset), .apbReq(apbReq), .apbRsp(apbRsp),
      .externalCountInput(external_count_input), .extOscClk(extOsc), .lfOscClk(lfOsc),
      .channelIoIn(chIn), .timer0Overflow(t0Ovf), .cpuIdle(cpuIdle),
      .globalIrqEnable(gie), .arrayIrqEnable(aie), .channelIoOut(chOut),
      .channelIoOe_n(chOe_n), .irqRequest(irq), .watchdogReset(wdtRst));

   cat_partner u_cat_partner (
      .clk(clk), .reset(reset), .t0Ovf(t0Ovf), .external_count_input(external_count_input), .extOsc(extOsc),
      .lfOsc(lfOsc));

   // ------------------------------------------------
   // helpers
   // ------------------------------------------------
   task automatic test_done();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // one apb transfer; the request holds until pready is seen at an edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge clk);
      apbReq.penable <= 1'b1;
      do @(posedge clk); while (apbRsp.pready !== 1'b1);
      rdq = apbRsp.prdata;
      rerr = apbRsp.pslverr;
      apbReq.psel <= 1'b0;
      apbReq.penable <= 1'b0;
   endtask

   // irq is combinational, so look at it mid-cycle after writes land
   task automatic irq_is(input logic exp);
      @(negedge clk);
      check({31'h0, irq}, {31'h0, exp}, "irq request");
      // hand back on a rising edge so the next input change lands there
      @(posedge clk);
   endtask

   // count advance over 240 cycles between two low-byte samples
   task automatic delta(input logic [7:0] mode, output logic [7:0] d);
      logic [7:0] first;
      apb(1'b1, `CAT_OFS_MODE, {24'h0, mode});
      apb(1'b0, `CAT_OFS_CNT_LOW, 32'h0);
      first = rdq[7:0];
      repeat (237) @(posedge clk);
      apb(1'b0, `CAT_OFS_CNT_LOW, 32'h0);
      d = rdq[7:0] - first;
   endtask

   // steps in 240 cycles given the partner's source periods
   function automatic logic [7:0] exp_delta(input logic [2:0] code);
      case (code)
         3'h0: return 8'hf0 / 8'h0c;
         3'h1: return 8'hf0 / 8'h04;
         3'h2: return 8'hf0 / 8'h06;
         3'h3: return 8'hf0 / 8'h0a;
         3'h4: return 8'hf0;
         3'h5: return 8'hf0 / (8'h06 * 8'h08);
         3'h6: return 8'hf0 / (8'h0a * 8'h08);
         default: return 8'h00;
      endcase
   endfunction

   // hang guard: the sequence needs well under 8000 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         test_done();
      end
   end

   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial begin
      void'($urandom(32'h16a8c5e4));
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      n = 0;
      while (wdtRst !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      check({31'h0, wdtRst}, 32'h1, "watchdog after reset");
      apb(1'b0, `CAT_OFS_MODE, 32'h0);
      check(rdq, 32'h40, "mode after reset");
      apb(1'b1, 12'h028, 32'hf);
      apb(1'b0, 12'h028, 32'h0);
      check(rdq, 32'h0, "locked channel mode");
      apb(1'b1, `CAT_OFS_MODE, 32'hbf);
      apb(1'b0, `CAT_OFS_MODE, 32'h0);
      check(rdq, 32'h0, "locked mode fields");
      apb(1'b0, 12'hffc, 32'h0);
      check({rdq[30:0], rerr}, 32'h1, "unmapped read");
      // random count bytes with the counter stopped (code 111)
      apb(1'b1, `CAT_OFS_MODE, 32'he);
      for (int i = 0; i < 4; i++) begin
         lo = 8'($urandom);
         hi = 8'($urandom);
         apb(1'b1, `CAT_OFS_CNT_LOW, {24'h0, lo});
         apb(1'b1, `CAT_OFS_CNT_HIGH, {24'h0, hi});
         apb(1'b0, `CAT_OFS_CNT_LOW, 32'h0);
         check(rdq, {24'h0, lo}, "count low");
         apb(1'b1, `CAT_OFS_CNT_HIGH, {24'h0, ~hi});
         apb(1'b0, `CAT_OFS_CNT_HIGH, 32'h0);
         check(rdq, {24'h0, hi}, "snapshot high");
      end
      // every timebase code, sampled by reads that must not disturb it
      for (int c = 0; c < 8; c++) begin
         delta({4'h0, 3'(c), 1'b0}, dl);
         check({24'h0, dl}, {24'h0, exp_delta(3'(c))}, "timebase");
      end
      cpuIdle <= 1'b1;
      delta(8'h88, dl);
      check({24'h0, dl}, 32'h0, "idle stop");
      delta(8'h08, dl);
      check({24'h0, dl}, 32'hf0, "idle run");
      cpuIdle <= 1'b0;
      // intermediate overflow for each carry position, three steps past it
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, `CAT_OFS_MODE, 32'he);
         apb(1'b1, `CAT_OFS_FLAGS, 32'h1f);
         apb(1'b1, `CAT_OFS_IRQEN, 32'(s << 4));
         apb(1'b1, `CAT_OFS_CNT_LOW, 32'hff);
         apb(1'b1, `CAT_OFS_CNT_HIGH, 32'((1 << s) - 1));
         apb(1'b1, `CAT_OFS_MODE, 32'h8);
         apb(1'b1, `CAT_OFS_MODE, 32'he);
         apb(1'b0, `CAT_OFS_FLAGS, 32'h0);
         check(rdq, 32'h08, "intermediate carry");
      end
      // full wrap with enables off, then walk the interrupt gating
      apb(1'b1, `CAT_OFS_IRQEN, 32'h0);
      apb(1'b1, `CAT_OFS_FLAGS, 32'h1f);
      apb(1'b1, `CAT_OFS_CNT_HIGH, 32'hff);
      apb(1'b1, `CAT_OFS_CNT_LOW, 32'hff);
      apb(1'b1, `CAT_OFS_MODE, 32'h8);
      apb(1'b1, `CAT_OFS_MODE, 32'he);
      apb(1'b0, `CAT_OFS_FLAGS, 32'h0);
      check(rdq, 32'h18, "wrap flags");
      irq_is(1'b0);
      apb(1'b1, `CAT_OFS_MODE, 32'hf);
      irq_is(1'b1);
      gie <= 1'b0;
      irq_is(1'b0);
      gie <= 1'b1;
      aie <= 1'b0;
      irq_is(1'b0);
      aie <= 1'b1;
      apb(1'b1, `CAT_OFS_FLAGS, 32'h10);
      apb(1'b0, `CAT_OFS_FLAGS, 32'h0);
      check(rdq, 32'h08, "software clear");
      irq_is(1'b0);
      apb(1'b1, `CAT_OFS_IRQEN, 32'h8);
      irq_is(1'b1);
      apb(1'b1, `CAT_OFS_FLAGS, 32'h8);
      irq_is(1'b0);
      // rising-edge capture on each channel pin
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, 12'(`CAT_OFS_CH_MODE + 4 * i), 32'h1);
         chIn[i] <= 1'b1;
         repeat (8) @(posedge clk);
         apb(1'b0, `CAT_OFS_FLAGS, 32'h0);
         check(rdq, 32'(1 << i), "capture flag");
         apb(1'b1, `CAT_OFS_IRQEN, 32'(1 << i));
         irq_is(1'b1);
         apb(1'b1, `CAT_OFS_FLAGS, 32'h7);
         irq_is(1'b0);
      end
      // match toggles channel 0 pin; channel 1 then captures a falling edge
      apb(1'b1, `CAT_OFS_CNT_LOW, 32'h10);
      apb(1'b1, `CAT_OFS_CNT_HIGH, 32'h0);
      apb(1'b1, `CAT_OFS_CH_VAL, 32'h14);
      apb(1'b1, `CAT_OFS_CH_MODE, 32'hc);
      apb(1'b1, 12'(`CAT_OFS_CH_MODE + 4), 32'h2);
      apb(1'b1, `CAT_OFS_FLAGS, 32'h7);
      check({29'h0, chOe_n}, 32'h6, "pin enables");
      apb(1'b1, `CAT_OFS_MODE, 32'h8);
      repeat (20) @(posedge clk);
      apb(1'b1, `CAT_OFS_MODE, 32'he);
      apb(1'b0, `CAT_OFS_FLAGS, 32'h0);
      check(rdq, 32'h1, "match flag");
      check({29'h0, chOut}, 32'h1, "match toggle");
      chIn[1] <= 1'b0;
      repeat (8) @(posedge clk);
      apb(1'b0, `CAT_OFS_FLAGS, 32'h0);
      check(rdq, 32'h3, "falling capture");
      test_done();
   end
endmodule
`default_nettype wire
